// *** rtl/irf_core.sv ***
// Infrared receive demodulator and RS485 request-to-send control.
//
// Our own choices: the address map and the strobed register port.
`include "irf_defines.svh"
`default_nettype none

module irf_core
	import irf_pkg::*;
#(
	parameter int FILTER_W = 8,
	parameter int RATIO_W = 11
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [3:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire logic rx_pin,
	input wire logic tx_rts_in,
	input wire logic transmitter_idle_flag,
	input wire logic [15:0] bit_time_cycles,
	output logic rx_to_receiver,
	output logic rts_out
);

	// ------------------------------------------------------------------
	// Parameter check
	// ------------------------------------------------------------------
	// The ratio field must hold its 9-bit reset value and fit the read word.
	if (FILTER_W != 8) begin : g_filter_w_check
		$error("irf_core: the filter counter must be 8 bits wide");
	end
	if (RATIO_W < 9 || RATIO_W > 16) begin : g_ratio_w_check
		$error("irf_core: the ratio field must be 9 to 16 bits wide");
	end

	// ------------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------------
	logic [1:0] rst_sync_reg;
	logic rst_n;

	// Reset is taken at once but let go only after two clock edges, so no
	// register leaves reset on an edge that is too close to its release.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		logic rx_s1;
		logic rx_s2;
		logic rx_prev;
		irf_state_t state;
		logic [FILTER_W-1:0] count;
		logic [15:0] bit_cnt;
		logic [FILTER_W-1:0] rx_glitch_filter_value;
		logic [RATIO_W-1:0] clock_ratio_divisor;
		logic irda_en;
		logic rs485_en;
		logic rx_out;
		logic rts;
		logic [31:0] rdata;
	} irf_regs_t;

	irf_regs_t st_reg;
	irf_regs_t st_next;

	// ------------------------------------------------------------------
	// Register read
	// ------------------------------------------------------------------
	// Unmapped offsets read as zero; the status word is live, not latched.
	function automatic logic [31:0] irf_read(irf_regs_t s, logic [3:0] a);
		logic [31:0] v;
		v = 32'h0;
		case (a)
			`IRF_FILTER_OFS: v[FILTER_W-1:0] = s.rx_glitch_filter_value;
			`IRF_RATIO_OFS: v[RATIO_W-1:0] = s.clock_ratio_divisor;
			`IRF_MODE_OFS: begin
				v[`IRF_MODE_IRDA_BIT] = s.irda_en;
				v[`IRF_MODE_RS485_BIT] = s.rs485_en;
			end
			`IRF_STATUS_OFS: begin
				v[`IRF_STAT_IDLE_BIT] = transmitter_idle_flag;
				v[`IRF_STAT_RXD_BIT] = s.rx_out;
				v[`IRF_STAT_RATIO_OK_BIT] = (s.clock_ratio_divisor != '0);
			end
			default: v = 32'h0;
		endcase
		return v;
	endfunction

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		logic fall;
		logic rise;
		// Edges are seen only behind the two synchroniser stages, so a
		// pin change that lands near a clock edge cannot split the logic.
		fall = st_reg.rx_prev && !st_reg.rx_s2;
		rise = !st_reg.rx_prev && st_reg.rx_s2;
		st_next = st_reg;
		st_next.rx_s1 = rx_pin;
		st_next.rx_s2 = st_reg.rx_s1;
		st_next.rx_prev = st_reg.rx_s2;
		st_next.rdata = rd ? irf_read(st_reg, addr) : 32'h0;

		if (wr) begin
			case (addr)
				`IRF_FILTER_OFS:
					st_next.rx_glitch_filter_value = wdata[FILTER_W-1:0];
				`IRF_RATIO_OFS:
					st_next.clock_ratio_divisor = wdata[RATIO_W-1:0];
				`IRF_MODE_OFS: begin
					st_next.irda_en = wdata[`IRF_MODE_IRDA_BIT];
					st_next.rs485_en = wdata[`IRF_MODE_RS485_BIT];
				end
				default: ;
			endcase
		end

		// The pulse toward the receiver runs to its end even if the line
		// moves meanwhile, so one qualified low gives one full bit.
		case (st_reg.state)
			IRF_IDLE: begin
				st_next.count = st_reg.rx_glitch_filter_value;
				if (st_reg.irda_en && fall) begin
					st_next.state = IRF_COUNT;
				end
			end
			IRF_COUNT: begin
				if (rise || !st_reg.irda_en) begin
					st_next.state = IRF_IDLE;
					st_next.count = st_reg.rx_glitch_filter_value;
				end else if (st_reg.count == '0) begin
					// A zero ratio stalls the shared smart-card timing, so
					// the qualified low is dropped instead of passed on.
					if (st_reg.clock_ratio_divisor != '0) begin
						st_next.state = IRF_PULSE;
						st_next.rx_out = 1'b0;
						st_next.bit_cnt = 16'h0001;
					end else begin
						st_next.state = IRF_IDLE;
					end
				end else begin
					st_next.count = st_reg.count - 1'b1;
				end
			end
			IRF_PULSE: begin
				if (st_reg.bit_cnt >= bit_time_cycles) begin
					st_next.state = IRF_IDLE;
					st_next.rx_out = 1'b1;
					st_next.count = st_reg.rx_glitch_filter_value;
				end else begin
					st_next.bit_cnt = st_reg.bit_cnt + 16'h0001;
				end
			end
			default: st_next.state = IRF_IDLE;
		endcase

		// Outside infrared mode, once the state is back in IRF_IDLE, the receiver sees the synchronised pin.
		if (!st_reg.irda_en && st_reg.state == IRF_IDLE) begin
			st_next.rx_out = st_reg.rx_s2;
		end

		// Request-to-send is registered so the pin never glitches when the
		// idle flag and the mode bit change on the same edge.
		st_next.rts = st_reg.rs485_en ? !transmitter_idle_flag
			: tx_rts_in;
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '{
				rx_s1: 1'b1,
				rx_s2: 1'b1,
				rx_prev: 1'b1,
				state: IRF_IDLE,
				count: FILTER_W'(`IRF_FILTER_RST),
				bit_cnt: 16'h0000,
				rx_glitch_filter_value: FILTER_W'(`IRF_FILTER_RST),
				clock_ratio_divisor: RATIO_W'(`IRF_RATIO_RST),
				irda_en: 1'b0,
				rs485_en: 1'b0,
				rx_out: 1'b1,
				rts: 1'b0,
				rdata: 32'h0
			};
		end else begin
			st_reg <= st_next;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign rdata = st_reg.rdata;
	assign rx_to_receiver = st_reg.rx_out;
	assign rts_out = st_reg.rts;

endmodule // irf_core

`default_nettype wire

// *** rtl/irf_defines.svh ***
// Constants for the infrared receive filter and RS485 drive block.
`ifndef IRF_DEFINES_SVH
`define IRF_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define IRF_FILTER_OFS 4'h0
`define IRF_RATIO_OFS 4'h4
`define IRF_MODE_OFS 4'h8
`define IRF_STATUS_OFS 4'hC

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define IRF_MODE_IRDA_BIT 0
`define IRF_MODE_RS485_BIT 1
`define IRF_STAT_IDLE_BIT 0
`define IRF_STAT_RXD_BIT 1
`define IRF_STAT_RATIO_OK_BIT 2
`define IRF_FILTER_RST 8'h00
`define IRF_RATIO_RST 11'h174
`define IRF_MODE_RST 2'h0

`endif

// *** rtl/irf_pkg.sv ***
// Types for the infrared receive filter and RS485 drive block.
`default_nettype none

package irf_pkg;

	typedef enum logic [1:0] {
		IRF_IDLE,
		IRF_COUNT,
		IRF_PULSE
	} irf_state_t;

endpackage

`default_nettype wire

// *** test/irf_core_sva.sv ***
// Assertion checker for the infrared filter block.
`default_nettype none
module irf_core_sva(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [3:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rx_pin,
	input wire logic tx_rts_in,
	input wire logic transmitter_idle_flag,
	input wire logic [15:0] bit_time_cycles,
	input wire logic rx_to_receiver,
	input wire logic rts_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] md_reg;
	logic [7:0] f_reg;
	logic z_reg;
	logic [8:0] lo_reg;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) {md_reg, f_reg, z_reg, lo_reg} <= '0;
		else begin
			if (wr && addr == 4'h0) f_reg <= wdata[7:0];
			if (wr && addr == 4'h4) z_reg <= wdata[10:0] == 11'h000;
			if (wr && addr == 4'h8) md_reg <= wdata[1:0];
			lo_reg <= rx_pin ? 9'h000 : lo_reg + 9'h001;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	a_fall_delay: assert property (
		$fell(rx_to_receiver) && md_reg[0] |-> lo_reg - f_reg inside {[3:7]})
		else $error("bad delay");
	a_pulse_width: assert property (
		$fell(rx_to_receiver) && md_reg[0] && bit_time_cycles == 16'h0004
		|=> !rx_to_receiver [*3] ##1 rx_to_receiver) else $error("bad width");
	a_ratio_zero: assert property (
		md_reg[0] && z_reg && $past(z_reg, 2) |-> !$fell(rx_to_receiver))
		else $error("pulse at zero ratio");
	a_rts_rs485: assert property (
		md_reg[1] && $past(md_reg[1], 2)
		|-> rts_out == !$past(transmitter_idle_flag)) else $error("bad rts");
	a_rts_plain: assert property (
		!md_reg[1] && !$past(md_reg[1], 2) && $past(reset_n, 3)
		|-> rts_out == $past(tx_rts_in)) else $error("rts not passed");
	a_short_low: assert property (
		md_reg[0] && $rose(rx_pin) && lo_reg <= {1'b0, f_reg} + 9'h001
		|-> (!$fell(rx_to_receiver)) [*6]) else $error("short low passed");
endmodule // irf_core_sva
bind irf_core irf_core_sva irf_core_sva_inst(.*);
`default_nettype wire

// *** test/irf_ir_xcvr.sv ***
// Infrared transceiver model that drives the receive line.
`default_nettype none
module irf_ir_xcvr(
	input wire logic clk,
	output logic rx_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	initial rx_pin = 1'b1;
	task automatic flash(input int n);
		rx_pin <= 1'b0;
		repeat (n) @(posedge clk);
		rx_pin <= 1'b1;
	endtask
endmodule // irf_ir_xcvr
`default_nettype wire

// *** test/tb.sv ***
// Bench for the infrared filter block.
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, reset_n, wr, rd, tx_rts_in, idle;
	logic rx_pin, rx_to_receiver, rts_out;
	logic [3:0] addr;
	logic [31:0] wdata, rdata;
	int fail_count = 0, compares = 0, n;
	int lv[3] = '{3, 20, 30}, fv[3] = '{5, 5, 11};
	irf_core irf_core_inst(.*, .transmitter_idle_flag(idle),
		.bit_time_cycles(16'h0004));
	irf_ir_xcvr irf_ir_xcvr_inst(.clk, .rx_pin);
	initial forever #50 clk = ~clk;
	task automatic chk(input logic [31:0] got, exp);
		compares++;
		if (got !== exp) fail_count++;
		if (got !== exp) $display("[ERR] %0t bad %h", $time, got);
	endtask
	task automatic bus(input logic w, logic [3:0] a, logic [31:0] d);
		@(posedge clk);
		{addr, wdata, wr, rd} <= {a, d, w, !w};
		@(posedge clk);
		{wr, rd} <= 2'h0;
		@(negedge clk);
		if (!w) chk(rdata, d);
	endtask
	task automatic ir(input int len, f, logic fall);
		@(posedge clk);
		fork irf_ir_xcvr_inst.flash(len); join_none
		for (n = 0; rx_to_receiver === 1'b1 && n < 40; n++) @(negedge clk);
		chk(n - f inside {[4:8]}, fall);
		repeat (40) @(posedge clk);
	endtask
	task automatic stop_test;
		if (fail_count == 0 && compares > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		{wr, rd, tx_rts_in, addr, wdata, reset_n} = '0;
		idle = 1'b1;
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk);
		bus(0, 4'h4, 32'h174);
		bus(0, 4'h2, 32'h0);
		bus(0, 4'h0, 32'h0);
		bus(0, 4'hC, 32'h7);
		bus(1, 4'h8, 32'h1);
		bus(0, 4'h8, 32'h1);
		for (int i = 0; i < 3; i++) begin
			bus(1, 4'h0, fv[i]);
			bus(0, 4'h0, fv[i]);
			ir(lv[i], fv[i], i > 0);
		end
		bus(1, 4'h4, 32'h0);
		bus(0, 4'hC, 32'h3);
		ir(20, 11, 0);
		bus(1, 4'h8, 32'h2);
		@(posedge clk);
		idle <= 1'b0;
		repeat (3) @(negedge clk);
		chk(rts_out, 1);
		@(posedge clk);
		{idle, tx_rts_in} <= 2'h3;
		repeat (3) @(negedge clk);
		chk(rts_out, 0);
		bus(1, 4'h8, 32'h0);
		repeat (3) @(negedge clk);
		chk(rts_out, 1);
		@(posedge clk);
		reset_n <= 1'b0;
		@(negedge clk);
		chk(rts_out, 0);
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk);
		bus(0, 4'h4, 32'h174);
		bus(0, 4'h0, 32'h0);
		chk(rts_out, 1);
		@(posedge clk);
		tx_rts_in <= 1'b0;
		repeat (3) @(negedge clk);
		chk(rts_out, 0);
		stop_test();
	end
endmodule // tb
`default_nettype wire
